// ===== pbu_pkg.sv
/*
 * Shared constants and types of the pixel back end: command header layout,
 * stencil operation codes, command decoder states, dither matrix, colour format.
 * Assumes a single pipeline clock; every user writes pbu_pkg::name.
 */
// Behaviour
// - header codes 3, 3, 1, 01; length 3
// - dwords one to four load red, green, blue, alpha
// - no post-blend clamp while blending is off
// - clamp enable applies the configured clamp range
// - blending always clamps to render-target range
// - dither value from 4x4 matrix at offset coordinates
// - two LSBs of X pick column, Y row
// - shifted dither added, then truncated to depth
// - stencil updates need test on; back set two-sided
// - fail, pass-depth-fail, pass-pass pick the operation
// - keep, zero, ref, sat inc/dec, wrap inc/dec, invert
// - operation codes 0 to 7 in that order
// - stencil written only with its write enable
// - stencil write mask keeps bits whose mask is 0
// - stencil writes independent of depth write enable
// - depth written only with depth write enable
// - untested or passing depth writes the pixel depth
// - depth fail keeps depth, colour; stencil still updates
// - sRGB targets gamma-encode RGB, never alpha
// - only channels present in the format are written
// - per-channel write disable leaves a channel untouched
`default_nettype none
package pbu_pkg;
	// command header fields and positions
	localparam logic [2:0] GRAPHICS_PIPE_CMD_TYPE = 3'h3;
	localparam logic [1:0] RENDER_PIPE_SUBTYPE    = 2'h3;
	localparam logic [2:0] UNQUEUED_STATE_OPCODE  = 3'h1;
	localparam logic [7:0] SET_BLEND_CONSTANT_CMD = 8'h01;
	localparam logic [7:0] CMD_LEN_BC             = 8'h03;
	localparam int         HDR_TYPE_LSB           = 29;
	localparam int         HDR_SUB_LSB            = 27;
	localparam int         HDR_OPC_LSB            = 24;
	localparam int         HDR_SUBOPC_LSB         = 16;
	localparam logic [31:0] BLEND_CONST_RESET = 32'h0000_0000;

	// colour component: signed fixed point, 12 fraction bits
	localparam int          COMP_FRAC = 12;
	localparam logic [15:0] COMP_ONE  = 16'h1000;
	localparam logic [3:0]  COMP_MAX_BITS = 4'h8;

	typedef enum logic [2:0] {
		STENCIL_KEEP,
		STENCIL_CLEAR,
		STENCIL_LOAD_REF,
		STENCIL_INC_CLAMP,
		STENCIL_DEC_CLAMP,
		STENCIL_INC_WRAP,
		STENCIL_DEC_WRAP,
		STENCIL_FLIP_BITS
	} pbu_sop_e;

	typedef enum logic [2:0] {
		CMD_IDLE,
		CMD_RED,
		CMD_GREEN,
		CMD_BLUE,
		CMD_ALPHA
	} pbu_cmd_e;

	// ordered 4x4 dither matrix, index {row, column}
	localparam logic [15:0][3:0] DITHER_MATRIX = {
		4'h5, 4'hd, 4'h7, 4'hf,
		4'h9, 4'h1, 4'hb, 4'h3,
		4'h6, 4'he, 4'h4, 4'hc,
		4'ha, 4'h2, 4'h8, 4'h0
	};
endpackage : pbu_pkg
`default_nettype wire

// ===== pbu_stencil_alu.sv
/*
 * Stencil value operation: applies one of the eight stencil operations.
 * Purely combinational; the caller selects the operation and applies the mask.
 */
`default_nettype none
module pbu_stencil_alu (
	// operands
	input  wire logic [7:0]       cur,
	input  wire logic [7:0]       ref_val,
	input  wire pbu_pkg::pbu_sop_e op,
	// result
	output logic      [7:0]       result
);
	always_comb begin
		unique case (op)
			pbu_pkg::STENCIL_KEEP:      result = cur;
			pbu_pkg::STENCIL_CLEAR:     result = 8'h00;
			pbu_pkg::STENCIL_LOAD_REF:  result = ref_val;
			pbu_pkg::STENCIL_INC_CLAMP: result = (cur == 8'hff) ? cur : 8'(cur + 8'h01);
			pbu_pkg::STENCIL_DEC_CLAMP: result = (cur == 8'h00) ? cur : 8'(cur - 8'h01);
			pbu_pkg::STENCIL_INC_WRAP:  result = 8'(cur + 8'h01);
			pbu_pkg::STENCIL_DEC_WRAP:  result = 8'(cur - 8'h01);
			pbu_pkg::STENCIL_FLIP_BITS: result = ~cur;
		endcase
	end
endmodule : pbu_stencil_alu
`default_nettype wire

// ===== pbu_colour_quant.sv
/*
 * One colour channel: optional sRGB encode, ordered dither, truncation.
 * Input is clamped by the caller only while blending is on; values outside [0,1] saturate here.
 */
`default_nettype none
module pbu_colour_quant (
	// channel value and format
	input  wire logic signed [15:0] value,
	input  wire logic               srgb,
	input  wire logic [3:0]         depth_bits,
	// dither
	input  wire logic               dither_en,
	input  wire logic [3:0]         dither,
	// quantized channel
	output logic      [7:0]         result
);
	// x^(1/2.4) at sixteenths; linear interpolation keeps error near one lsb above the first sixteenth
	function automatic logic [12:0] gamma_lut(input logic [4:0] i);
		unique case (i)
			5'h00: gamma_lut = 13'h0000; 5'h01: gamma_lut = 13'h050a;
			5'h02: gamma_lut = 13'h06ba; 5'h03: gamma_lut = 13'h07f7;
			5'h04: gamma_lut = 13'h08fb; 5'h05: gamma_lut = 13'h09db;
			5'h06: gamma_lut = 13'h0aa2; 5'h07: gamma_lut = 13'h0b56;
			5'h08: gamma_lut = 13'h0bfd; 5'h09: gamma_lut = 13'h0c97;
			5'h0a: gamma_lut = 13'h0d28; 5'h0b: gamma_lut = 13'h0db0;
			5'h0c: gamma_lut = 13'h0e31; 5'h0d: gamma_lut = 13'h0ead;
			5'h0e: gamma_lut = 13'h0f22; 5'h0f: gamma_lut = 13'h0f94;
			default: gamma_lut = 13'h1000;
		endcase
	endfunction : gamma_lut

	function automatic logic [12:0] gamma_enc(input logic [12:0] x);
		logic [12:0] y0;
		logic [12:0] y1;
		logic [20:0] p;
		y0 = gamma_lut({1'b0, x[11:8]});
		y1 = gamma_lut(5'({1'b0, x[11:8]} + 5'h01));
		p  = 21'(13'(y1 - y0) * x[7:0]);
		gamma_enc = x[12] ? 13'h1000 : 13'(y0 + p[20:8]);
	endfunction : gamma_enc

	logic [12:0] lin;
	logic [12:0] enc;
	logic [3:0]  bits;
	logic [3:0]  sh;
	logic [13:0] dval;
	logic [13:0] sum;
	logic [13:0] q;
	logic [13:0] maxv;

	always_comb begin
		if (value < 0)
			lin = 13'h0000;
		else if (value > signed'(pbu_pkg::COMP_ONE))
			lin = 13'(pbu_pkg::COMP_ONE);
		else
			lin = value[12:0];
		enc  = srgb ? gamma_enc(lin) : lin;
		bits = (depth_bits == 4'h0 || depth_bits > pbu_pkg::COMP_MAX_BITS) ?
			pbu_pkg::COMP_MAX_BITS : depth_bits;
		sh   = 4'(pbu_pkg::COMP_FRAC) - bits;
		// dither msb sits just below the lowest kept bit
		dval = dither_en ? (14'(dither) << 4'(sh - 4'h4)) : 14'h0000;
		sum  = 14'({1'b0, enc}) + dval;
		q    = sum >> sh;
		maxv = 14'((14'h0001 << bits) - 14'h0001);
		result = (q > maxv) ? maxv[7:0] : q[7:0];
	end
endmodule : pbu_colour_quant
`default_nettype wire

// ===== pbu_backend.sv
/*
 * Pixel back end: blend constant command, post-blend clamp, dither and
 * stencil/depth/colour buffer update, one pixel per enabled cycle, latency one.
 * Assumes test results arrive with the pixel and memory accepts every write.
 */
`default_nettype none
module pbu_backend (
	// clock, reset, enable
	input  wire logic               clk_sys,
	input  wire logic               sys_rst,
	input  wire logic               ce,
	// command stream
	input  wire logic               cmd_valid,
	input  wire logic [31:0]        cmd_data,
	// blend constant
	output logic      [31:0]        blend_const_red,
	output logic      [31:0]        blend_const_green,
	output logic      [31:0]        blend_const_blue,
	output logic      [31:0]        blend_const_alpha,
	// pixel in
	input  wire logic               px_valid,
	input  wire logic               px_kill,
	input  wire logic [11:0]        px_x,
	input  wire logic [11:0]        px_y,
	input  wire logic               px_back_face,
	input  wire logic               stencil_pass,
	input  wire logic               depth_pass,
	input  wire logic [31:0]        px_depth,
	input  wire logic [7:0]         px_stencil,
	input  wire logic signed [15:0] px_red,
	input  wire logic signed [15:0] px_green,
	input  wire logic signed [15:0] px_blue,
	input  wire logic signed [15:0] px_alpha,
	// colour state
	input  wire logic               blend_en,
	input  wire logic               post_clamp_en,
	input  wire logic signed [15:0] clamp_lo,
	input  wire logic signed [15:0] clamp_hi,
	input  wire logic signed [15:0] rt_lo,
	input  wire logic signed [15:0] rt_hi,
	input  wire logic               rt_srgb,
	input  wire logic [3:0]         rt_bits,
	input  wire logic [3:0]         rt_has_chan,
	input  wire logic [3:0]         chan_write_dis,
	input  wire logic               dither_en,
	input  wire logic [1:0]         dither_off_x,
	input  wire logic [1:0]         dither_off_y,
	// depth and stencil state
	input  wire logic               depth_test_en,
	input  wire logic               depth_write_en,
	input  wire logic               stencil_test_en,
	input  wire logic               stencil_write_en,
	input  wire logic               two_sided_en,
	input  wire logic [8:0]         front_ops,
	input  wire logic [8:0]         back_ops,
	input  wire logic [7:0]         front_ref,
	input  wire logic [7:0]         back_ref,
	input  wire logic [7:0]         front_wmask,
	input  wire logic [7:0]         back_wmask,
	// buffer writes
	output logic                    out_valid,
	output logic                    depth_we,
	output logic      [31:0]        depth_data,
	output logic                    stencil_we,
	output logic      [7:0]         stencil_data,
	output logic      [3:0]         colour_we,
	output logic      [7:0]         colour_red,
	output logic      [7:0]         colour_green,
	output logic      [7:0]         colour_blue,
	output logic      [7:0]         colour_alpha
);
	typedef struct packed {
		pbu_pkg::pbu_cmd_e st;
		logic [3:0][31:0]  bconst;
		logic              out_valid;
		logic              depth_we;
		logic [31:0]       depth_data;
		logic              stencil_we;
		logic [7:0]        stencil_data;
		logic [3:0]        colour_we;
		logic [3:0][7:0]   colour;
	} pbu_state_s;

	pbu_state_s q;
	pbu_state_s next_q;

	function automatic logic hdr_ok(input logic [31:0] w);
		hdr_ok = w[31:pbu_pkg::HDR_TYPE_LSB] == pbu_pkg::GRAPHICS_PIPE_CMD_TYPE &&
			w[pbu_pkg::HDR_TYPE_LSB-1:pbu_pkg::HDR_SUB_LSB] == pbu_pkg::RENDER_PIPE_SUBTYPE &&
			w[pbu_pkg::HDR_SUB_LSB-1:pbu_pkg::HDR_OPC_LSB] == pbu_pkg::UNQUEUED_STATE_OPCODE &&
			w[pbu_pkg::HDR_OPC_LSB-1:pbu_pkg::HDR_SUBOPC_LSB] == pbu_pkg::SET_BLEND_CONSTANT_CMD &&
			w[7:0] == pbu_pkg::CMD_LEN_BC;
	endfunction : hdr_ok

	function automatic logic signed [15:0] clamp(input logic signed [15:0] v,
		input logic signed [15:0] lo, input logic signed [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp

	// colour path
	logic signed [3:0][15:0] px_col;
	logic signed [3:0][15:0] blended;
	logic [3:0][7:0]         quant;
	logic [3:0]              dither;
	logic [1:0]              dcol;
	logic [1:0]              drow;

	always_comb begin
		px_col = {px_alpha, px_blue, px_green, px_red};
		for (int c = 0; c < 4; c++) begin
			blended[c] = px_col[c];
			if (blend_en) begin
				if (post_clamp_en)
					blended[c] = clamp(blended[c], clamp_lo, clamp_hi);
				blended[c] = clamp(blended[c], rt_lo, rt_hi);
			end
		end
		dcol   = 2'(px_x[1:0] + dither_off_x);
		drow   = 2'(px_y[1:0] + dither_off_y);
		dither = pbu_pkg::DITHER_MATRIX[{drow, dcol}];
	end

	for (genvar c = 0; c < 4; c++) begin : g_chan
		pbu_colour_quant u_quant (
			.value      (blended[c]),
			.srgb       (rt_srgb && c != 3),
			.depth_bits (rt_bits),
			.dither_en  (dither_en),
			.dither     (dither),
			.result     (quant[c])
		);
	end

	// stencil path
	logic [8:0]        ops;
	logic [7:0]        sref;
	logic [7:0]        wmask;
	logic              use_back;
	logic              live;
	logic              sten_ok;
	logic              depth_ok;
	logic [7:0]        sten_new;
	pbu_pkg::pbu_sop_e sop;

	always_comb begin
		use_back = two_sided_en && px_back_face;
		ops      = use_back ? back_ops : front_ops;
		sref     = use_back ? back_ref : front_ref;
		wmask    = use_back ? back_wmask : front_wmask;
		live     = px_valid && !px_kill;
		sten_ok  = !stencil_test_en || stencil_pass;
		depth_ok = !depth_test_en || depth_pass;
		if (!stencil_pass)
			sop = pbu_pkg::pbu_sop_e'(ops[8:6]);
		else if (!depth_ok)
			sop = pbu_pkg::pbu_sop_e'(ops[5:3]);
		else
			sop = pbu_pkg::pbu_sop_e'(ops[2:0]);
	end

	pbu_stencil_alu u_stencil (
		.cur     (px_stencil),
		.ref_val (sref),
		.op      (sop),
		.result  (sten_new)
	);

	always_comb begin
		next_q = q;
		if (cmd_valid) begin
			unique case (q.st)
				pbu_pkg::CMD_IDLE:
					// a foreign or mis-sized header is dropped a dword at a time
					if (hdr_ok(cmd_data))
						next_q.st = pbu_pkg::CMD_RED;
				pbu_pkg::CMD_RED: begin
					next_q.bconst[0] = cmd_data;
					next_q.st        = pbu_pkg::CMD_GREEN;
				end
				pbu_pkg::CMD_GREEN: begin
					next_q.bconst[1] = cmd_data;
					next_q.st        = pbu_pkg::CMD_BLUE;
				end
				pbu_pkg::CMD_BLUE: begin
					next_q.bconst[2] = cmd_data;
					next_q.st        = pbu_pkg::CMD_ALPHA;
				end
				pbu_pkg::CMD_ALPHA: begin
					next_q.bconst[3] = cmd_data;
					next_q.st        = pbu_pkg::CMD_IDLE;
				end
				default:
					next_q.st = pbu_pkg::CMD_IDLE;
			endcase
		end
		next_q.out_valid    = px_valid;
		next_q.depth_we     = live && sten_ok && depth_ok && depth_write_en;
		next_q.depth_data   = px_depth;
		next_q.stencil_we   = live && stencil_test_en && stencil_write_en;
		next_q.stencil_data = (px_stencil & ~wmask) | (sten_new & wmask);
		next_q.colour_we    = (live && sten_ok && depth_ok) ?
			(rt_has_chan & ~chan_write_dis) : 4'h0;
		next_q.colour       = quant;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			q.st           <= pbu_pkg::CMD_IDLE;
			q.bconst       <= {4{pbu_pkg::BLEND_CONST_RESET}};
			q.out_valid    <= 1'b0;
			q.depth_we     <= 1'b0;
			q.depth_data   <= 32'h0000_0000;
			q.stencil_we   <= 1'b0;
			q.stencil_data <= 8'h00;
			q.colour_we    <= 4'h0;
			q.colour       <= 32'h0000_0000;
		end else if (ce) begin
			q <= next_q;
		end
	end

	assign blend_const_red   = q.bconst[0];
	assign blend_const_green = q.bconst[1];
	assign blend_const_blue  = q.bconst[2];
	assign blend_const_alpha = q.bconst[3];
	assign out_valid         = q.out_valid;
	assign depth_we          = q.depth_we;
	assign depth_data        = q.depth_data;
	assign stencil_we        = q.stencil_we;
	assign stencil_data      = q.stencil_data;
	assign colour_we         = q.colour_we;
	assign colour_red        = q.colour[0];
	assign colour_green      = q.colour[1];
	assign colour_blue       = q.colour[2];
	assign colour_alpha      = q.colour[3];

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_hdr;
		ce && cmd_valid && q.st == pbu_pkg::CMD_IDLE && hdr_ok(cmd_data);
	endsequence
	sequence s_load;
		s_hdr ##1 (ce && cmd_valid) [*4];
	endsequence

	a_const_load: assert property (s_load |=> blend_const_red == $past(cmd_data, 4) &&
		blend_const_alpha == $past(cmd_data))
		else $error("blend constant not loaded from command");
	a_const_hold: assert property ((!ce || !cmd_valid || q.st == pbu_pkg::CMD_IDLE) |=>
		$stable(q.bconst))
		else $error("blend constant changed without a load");
	a_depth_gate: assert property (ce && !depth_write_en |=> !depth_we)
		else $error("depth written with write enable clear");
	a_depth_fail: assert property (ce && px_valid && depth_test_en && !depth_pass |=>
		!depth_we && colour_we == 4'h0)
		else $error("failed depth test still wrote depth or colour");
	a_depth_data: assert property (ce && depth_write_en && live && !depth_test_en &&
		sten_ok |=> depth_we && depth_data == $past(px_depth))
		else $error("passing pixel depth not written");
	a_stencil_gate: assert property (ce && !(stencil_test_en && stencil_write_en) |=>
		!stencil_we)
		else $error("stencil written while disabled");
	a_stencil_mask: assert property (ce |=>
		((stencil_data ^ $past(px_stencil)) & ~$past(wmask)) == 8'h00)
		else $error("masked stencil bit modified");
	a_colour_dis: assert property (ce |=>
		(colour_we & ($past(chan_write_dis) | ~$past(rt_has_chan))) == 4'h0)
		else $error("disabled or absent channel written");
	a_post_clamp: assert property (blend_en |->
		$signed(blended[0]) >= rt_lo && $signed(blended[0]) <= rt_hi || rt_lo > rt_hi)
		else $error("blend output outside target range");

	// op and mask checks watch the registered merge, not the alu alone
	sequence s_sten_live;
		ce && live && stencil_test_en && stencil_write_en;
	endsequence

	a_ce_freeze: assert property (!ce |=> $stable(q))
		else $error("state moved while clock enable low");
	a_out_valid: assert property (ce |=> out_valid == $past(px_valid))
		else $error("pixel valid not carried to output");
	a_kill_quiet: assert property (ce && px_valid && px_kill |=>
		!depth_we && !stencil_we && colour_we == 4'h0)
		else $error("killed pixel wrote a buffer");
	a_stencil_free: assert property (s_sten_live ##0 !depth_write_en |=> stencil_we)
		else $error("stencil write blocked by depth write enable");
	a_sten_fail_op: assert property (s_sten_live ##0 (!stencil_pass &&
		ops[8:6] == pbu_pkg::STENCIL_CLEAR) |=> (stencil_data & $past(wmask)) == 8'h00)
		else $error("stencil fail operation not applied");
	a_sten_ref_op: assert property (s_sten_live ##0 (stencil_pass && !depth_ok &&
		ops[5:3] == pbu_pkg::STENCIL_LOAD_REF) |=> ((stencil_data ^ $past(sref)) & $past(wmask)) == 8'h00)
		else $error("stencil depth-fail operation not applied");
	a_back_mask: assert property (s_sten_live ##0 (two_sided_en && px_back_face) |=>
		((stencil_data ^ $past(px_stencil)) & ~$past(back_wmask)) == 8'h00)
		else $error("back-facing pixel not masked by back set");
	a_colour_en: assert property (ce && live && sten_ok && depth_ok |=>
		colour_we == ($past(rt_has_chan) & ~$past(chan_write_dis)))
		else $error("surviving pixel colour enables wrong");
	a_depth_pass: assert property (ce && live && sten_ok && depth_test_en && depth_pass &&
		depth_write_en |=> depth_we && depth_data == $past(px_depth))
		else $error("depth of passing pixel not written");
	a_blend_off: assert property (!blend_en |-> $signed(blended[1]) == px_green)
		else $error("colour altered with blending off");
endmodule : pbu_backend
`default_nettype wire

// ===== pbu_stream_src.sv
/*
 * Stream source standing in for the command streamer: sends blend constant
 * commands one dword at a time. Assumes the back end takes a dword at every enabled edge.
 */
`default_nettype none
module pbu_stream_src (
	// clock
	input  wire logic        clk_sys,
	// command stream
	output logic             cmd_valid,
	output logic      [31:0] cmd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_valid = 1'b0;
		cmd_data  = 32'h0;
	end
	// held to the taking edge; idle data shows the inverse so nothing stale looks valid
	task automatic put(input logic [31:0] w, input bit slow);
		cmd_valid = 1'b1;
		cmd_data  = w;
		@(posedge clk_sys);
		#1;
		if (slow) begin
			cmd_valid = 1'b0;
			cmd_data  = ~w;
			repeat (2) @(posedge clk_sys);
			#1;
		end
	endtask : put
	// header, then red, green, blue, alpha; bad sends a wrong length
	task automatic send_cmd(input logic [31:0] r, g, b, a, input bit slow, input bit bad);
		put({3'h3, 2'h3, 3'h1, 8'h01, 8'h00, bad ? 8'h04 : 8'h03}, slow);
		put(r, slow);
		put(g, slow);
		put(b, slow);
		put(a, slow);
		cmd_valid = 1'b0;
		cmd_data  = ~a;
	endtask : send_cmd
endmodule : pbu_stream_src
`default_nettype wire

// ===== test_pbu_backend.sv
/*
 * Bench of the pixel back end: random pixels against an integer model,
 * blend constant loads through the stream source. Assumes clk_sys at 50 MHz.
 */
`default_nettype none
module test_pbu_backend;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, sys_rst, ce, cmd_valid, px_valid, px_kill, px_back_face;
	logic stencil_pass, depth_pass, blend_en, post_clamp_en, rt_srgb, dither_en;
	logic depth_test_en, depth_write_en, stencil_test_en, stencil_write_en, two_sided_en;
	logic out_valid, depth_we, stencil_we;
	logic [31:0] cmd_data, px_depth, depth_data;
	logic [31:0] blend_const_red, blend_const_green, blend_const_blue, blend_const_alpha;
	logic [11:0] px_x, px_y;
	logic [7:0] px_stencil, front_ref, back_ref, front_wmask, back_wmask, stencil_data;
	logic [7:0] colour_red, colour_green, colour_blue, colour_alpha;
	logic signed [15:0] px_red, px_green, px_blue, px_alpha, clamp_lo, clamp_hi, rt_lo, rt_hi;
	logic [3:0] rt_bits, rt_has_chan, chan_write_dis, colour_we;
	logic [1:0] dither_off_x, dither_off_y;
	logic [8:0] front_ops, back_ops;
	logic [31:0] bc[4], held[4];
	int failures, compares, cycles;
	int dm[16] = '{0, 8, 2, 10, 12, 4, 14, 6, 3, 11, 1, 9, 15, 7, 13, 5};

	pbu_backend u_pbu_backend (.*);
	pbu_stream_src u_pbu_stream_src (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_data(cmd_data));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// ceiling well above the roughly 850 cycles the tests need
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			results();
		end
	end

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	task automatic results();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results

	function automatic logic [7:0] sop(input int op, input logic [7:0] c, r);
		case (op)
			0: return c;
			1: return 8'h00;
			2: return r;
			3: return (c == 8'hff) ? c : c + 8'h01;
			4: return (c == 8'h00) ? c : c - 8'h01;
			5: return c + 8'h01;
			6: return c - 8'h01;
			default: return ~c;
		endcase
	endfunction : sop

	// reads the state inputs, so it is called while they still hold this pixel
	function automatic int qv(input int v, input int bits, input int dv);
		if (blend_en) begin
			if (post_clamp_en) v = (v < clamp_lo) ? clamp_lo : (v > clamp_hi) ? clamp_hi : v;
			v = (v < rt_lo) ? rt_lo : (v > rt_hi) ? rt_hi : v;
		end
		v = (v < 0) ? 0 : (v > 4096) ? 4096 : v;
		if (dither_en) v += dv << (8 - bits);
		v = v >> (12 - bits);
		return (v > (1 << bits) - 1) ? (1 << bits) - 1 : v;
	endfunction : qv

	task automatic rnd();
		px_valid = ($urandom % 8) != 0;
		px_kill = ($urandom % 8) == 0;
		// a depth buffer with 8-bit stencil always exists, so every enable is legal
		{stencil_pass, depth_pass, px_back_face, depth_test_en, depth_write_en,
			stencil_test_en, stencil_write_en, two_sided_en, blend_en, post_clamp_en,
			dither_en} = 11'($urandom);
		rt_srgb = ($urandom % 4) == 0;
		rt_bits = rt_srgb ? 4'h8 : 4'(1 + $urandom % 8);
		{front_ops, back_ops} = 18'($urandom);
		{front_ref, back_ref, front_wmask, back_wmask} = $urandom;
		{px_stencil, px_depth, px_x, px_y} = 64'({$urandom, $urandom});
		{dither_off_x, dither_off_y, rt_has_chan, chan_write_dis} = 12'($urandom);
		{px_red, px_green} = {16'($urandom % 8192 - 2048), 16'($urandom % 8192 - 2048)};
		{px_blue, px_alpha} = {16'($urandom % 8192 - 2048), 16'($urandom % 8192 - 2048)};
		clamp_lo = 16'($urandom % 4096 - 1024);
		clamp_hi = clamp_lo + 16'($urandom % 4096);
		rt_lo = ($urandom % 2) ? 16'h0000 : 16'hf000;
		rt_hi = 16'(2048 + $urandom % 2049);
	endtask : rnd

	// back to back pixels, each checked one enabled edge later
	task automatic pixel(input int n);
		int bits, dv, op, e[4];
		logic bk, surv, swe;
		logic [7:0] m, sexp;
		logic [8:0] ops;
		logic [3:0] cwe;
		repeat (n) begin
			rnd();
			bk = two_sided_en & px_back_face;
			surv = px_valid & !px_kill & (!stencil_test_en | stencil_pass) & (!depth_test_en | depth_pass);
			swe = px_valid & !px_kill & stencil_test_en & stencil_write_en;
			ops = bk ? back_ops : front_ops;
			op = !stencil_pass ? ops[8:6] : (depth_test_en & !depth_pass) ? ops[5:3] : ops[2:0];
			m = bk ? back_wmask : front_wmask;
			sexp = (px_stencil & ~m) | (sop(op, px_stencil, bk ? back_ref : front_ref) & m);
			cwe = surv ? rt_has_chan & ~chan_write_dis : 4'h0;
			bits = rt_bits;
			dv = dm[4 * ((px_y + dither_off_y) & 3) + ((px_x + dither_off_x) & 3)];
			e = '{qv(px_red, bits, dv), qv(px_green, bits, dv),
				qv(px_blue, bits, dv), qv(px_alpha, bits, dv)};
			@(posedge clk_sys);
			#1;
			chk_val(out_valid, px_valid);
			chk_val(depth_we, surv & depth_write_en);
			if (surv & depth_write_en) chk_val(depth_data, px_depth);
			chk_val(stencil_we, swe);
			if (swe) chk_val(stencil_data, sexp);
			chk_val(colour_we, cwe);
			if (cwe[3]) chk_val(colour_alpha, e[3]);
			if (!rt_srgb) begin
				if (cwe[0]) chk_val(colour_red, e[0]);
				if (cwe[1]) chk_val(colour_green, e[1]);
				if (cwe[2]) chk_val(colour_blue, e[2]);
			end else if (cwe[0] && e[0] > 8 && e[0] < 200) begin
				chk_val(colour_red > e[0], 1'b1);
			end
		end
	endtask : pixel

	// ce low: fresh pixels offered at the edge must leave every pixel output and blend_const_red as it was
	task automatic freeze(input int n);
		logic [31:0] s0, s1, s2;
		s0 = {colour_red, colour_green, colour_blue, colour_alpha};
		s1 = {17'h0, out_valid, depth_we, stencil_we, colour_we, stencil_data};
		s2 = depth_data;
		ce = 1'b0;
		repeat (n) begin
			rnd();
			@(posedge clk_sys);
			#1;
			chk_val({colour_red, colour_green, colour_blue, colour_alpha}, s0);
			chk_val({17'h0, out_valid, depth_we, stencil_we, colour_we, stencil_data}, s1);
			chk_val(depth_data, s2);
			chk_val(blend_const_red, held[0]);
		end
		ce = 1'b1;
	endtask : freeze

	initial begin
		void'($urandom(32'haefeeb45));
		rnd();
		px_valid = 1'b0;
		ce = 1'b1;
		sys_rst = 1'b1;
		repeat (12) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		chk_val(blend_const_red, 32'h0);
		chk_val({out_valid, depth_we, stencil_we, colour_we}, 32'h0);
		held = '{32'h0, 32'h0, 32'h0, 32'h0};
		$display("test reset done");
		// prompt load, slow load, then a bad header that must leave the constant alone
		for (int i = 0; i < 3; i++) begin
			bc = '{$urandom, $urandom, $urandom, $urandom};
			u_pbu_stream_src.send_cmd(bc[0], bc[1], bc[2], bc[3], i == 1, i == 2);
			if (i < 2) held = bc;
			pixel(4);
			chk_val(blend_const_red, held[0]);
			chk_val(blend_const_green, held[1]);
			chk_val(blend_const_blue, held[2]);
			chk_val(blend_const_alpha, held[3]);
			$display("test blend constant %0d done", i);
		end
		freeze(3);
		$display("test clock enable done");
		pixel(800);
		$display("test random pixels done");
		results();
	end
endmodule : test_pbu_backend
`default_nettype wire
